// ### design/rx_buffer_size.sv
module rx_buffer_size (
   // Receive control fields
   input  wire logic [1:0]  buffer_size_field,
   input  wire logic        buffer_size_extension,
   input  wire logic [1:0]  descriptor_type,
   input  wire logic [3:0]  flexible_buffer_size,
   // Resulting size in bytes
   output logic      [15:0] size_bytes
);
   import rx_wb_pkg::*;

   // Descriptor type 11 forces the size of the one buffer this block fills to 2048 bytes.
   always_comb begin
      size_bytes = BUF_2048;
      if (flexible_buffer_size != 4'h0) begin
         size_bytes = {2'b00, flexible_buffer_size, 10'h000};
      end else if (buffer_size_extension) begin
         case (buffer_size_field)
            2'b01:   size_bytes = BUF_16384;
            2'b10:   size_bytes = BUF_8192;
            2'b11:   size_bytes = BUF_4096;
            default: size_bytes = BUF_2048;
         endcase
      end else begin
         case (buffer_size_field)
            2'b01:   size_bytes = BUF_1024;
            2'b10:   size_bytes = BUF_512;
            2'b11:   size_bytes = BUF_256;
            default: size_bytes = BUF_2048;
         endcase
      end
      if (descriptor_type == 2'b11) begin
         size_bytes = BUF_2048;
      end
   end

endmodule

// ### design/rx_descriptor_writeback.sv
// What this block does
// - Matching tagged frame: record tag, strip bytes
// - Untagged frame writes zero tag field
// - Tag holds identifier, format flag, priority
// - Extended format needs status enable, type 00
// - Read word zero is buffer address
// - Buffer size from receive control fields
// - Done bit set when descriptor finished
// - End of packet only in last descriptor
// - Queue field: type 3:0, queue 12:8
// - Queue reserved when multi-queue disabled
// - Hash type codes; reserved codes written zero
// - Packet checksum at word zero 63:48
// - Checksum begins at programmed start offset
// - Stripped tag excluded from checksum and offset
// - IP identification at word zero 47:32
// - Extended status 19:0, reserved bits zero
// - Acknowledge bit, payload case by disable bit
module rx_descriptor_writeback (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Avalon-MM register slave
   input  wire logic [7:0]               avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic      [31:0]              avs_readdata,
   output logic                          avs_waitrequest,
   // Descriptors fetched from the host ring
   input  wire logic                     desc_valid,
   input  wire rx_wb_pkg::rx_desc_t      desc_in,
   output logic                          desc_ready,
   // Received frame bytes, meta valid with the last byte
   input  wire logic                     rx_valid,
   input  wire rx_wb_pkg::rx_byte_t      rx_in,
   input  wire rx_wb_pkg::frame_meta_t   rx_meta,
   output logic                          rx_ready,
   // Bytes stored to host memory
   output logic                          out_valid,
   output logic      [7:0]               out_data,
   output logic      [63:0]              out_addr,
   output logic                          out_last,
   // Descriptor write-back
   output logic                          wb_valid,
   output rx_wb_pkg::wb_desc_t           wb_out
);
   import rx_wb_pkg::*;

   typedef enum logic [1:0] {
      S_STREAM = 2'b01,
      S_FLUSH  = 2'b10
   } flow_t;

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [3:0] rss_code(input logic [3:0] t);
      case (t)
         RSS_V4_TCP, RSS_V4, RSS_V6_TCP, RSS_V6: rss_code = t;
         default:                                rss_code = RSS_NONE;
      endcase
   endfunction

   // Software registers.
   logic [31:0] ctrl_r;
   logic [15:0] vet_r;
   logic [7:0]  csum_start_r;
   logic [3:0]  flex_r;
   logic [15:0] buf_size;
   logic [15:0] frames_r;
   logic [7:0]  skipped_r;

   logic        vlan_mode_enable;
   logic        extended_status_enable;
   logic [1:0]  descriptor_type;
   logic        ack_data_disable;
   logic [1:0]  mrq_enable;

   assign vlan_mode_enable       = ctrl_r[VLAN_MODE_ENABLE];
   assign extended_status_enable = ctrl_r[CTRL_EXSTEN];
   assign descriptor_type        = ctrl_r[CTRL_DTYP_LO +: 2];
   assign ack_data_disable       = ctrl_r[CTRL_ACKD_DIS];
   assign mrq_enable             = ctrl_r[CTRL_MRQE_LO +: 2];

   // Frame path state.
   flow_t       state_r;
   logic        has_desc_r;
   logic        ext_fmt_r;
   logic [63:0] desc_addr_r;
   logic [15:0] desc_len_r;
   logic [15:0] desc_size_r;
   logic [15:0] in_idx_r;
   logic [7:0]  s0_data_r, s1_data_r;
   logic [15:0] s0_idx_r,  s1_idx_r;
   logic        s0_eop_r,  s1_eop_r;
   logic        s0_vld_r,  s1_vld_r;
   logic        tagged_r;
   logic [15:0] tci_r;
   logic [15:0] out_pos_r;
   frame_meta_t meta_r;
   logic [15:0] csum;

   // Write-back staging, one cycle so that the last byte is in the checksum.
   logic        wb_pend_r;
   logic        wb_eop_r;
   logic        wb_vp_r;
   logic        wb_ext_r;
   logic [15:0] wb_len_r;

   logic        req;
   logic        bus_acc;
   logic        accept;
   logic        take;
   logic        shift;
   logic        emit;
   logic        tag_hit;
   logic        in_tag;
   logic        drop;
   logic        keep;
   logic        desc_full;
   logic        close;
   logic        has_desc_nxt;
   flow_t       state_nxt;
   logic [15:0] desc_len_inc;
   logic [31:0] rd_mux;

   rx_buffer_size u_buf_size (
      .buffer_size_field     (ctrl_r[CTRL_BSIZE_LO +: 2]),
      .buffer_size_extension (ctrl_r[CTRL_BSEX]),
      .descriptor_type       (descriptor_type),
      .flexible_buffer_size  (flex_r),
      .size_bytes            (buf_size)
   );

   always_comb begin
      req          = avs_read | avs_write;
      bus_acc      = req & ~avs_waitrequest;
      accept       = rx_valid & rx_ready;
      take         = desc_valid & desc_ready;
      shift        = accept | ((state_r == S_FLUSH) & has_desc_r);
      emit         = shift & s1_vld_r;
      tag_hit      = vlan_mode_enable & s0_vld_r & (s1_idx_r == TYPE_HI_IDX)
                     & (s0_idx_r == TYPE_LO_IDX) & ({s1_data_r, s0_data_r} == vet_r);
      in_tag       = (s1_idx_r >= TYPE_HI_IDX) && (s1_idx_r <= TCI_LO_IDX);
      drop         = in_tag & ((s1_idx_r == TYPE_HI_IDX) ? tag_hit : tagged_r);
      keep         = emit & ~drop;
      desc_len_inc = desc_len_r + {15'h0000, keep};
      desc_full    = keep & (desc_len_inc == desc_size_r);
      close        = emit & (s1_eop_r | desc_full);
      has_desc_nxt = has_desc_r;
      if (close) begin
         has_desc_nxt = 1'b0;
      end else if (take && !desc_in.word1[ST_DD]) begin
         has_desc_nxt = 1'b1;
      end
      state_nxt = state_r;
      case (state_r)
         S_STREAM: if (accept && rx_in.eop) state_nxt = S_FLUSH;
         S_FLUSH:  if (emit && s1_eop_r) state_nxt = S_STREAM;
         default:  state_nxt = S_STREAM;
      endcase
   end

   // Avalon slave: one wait state, then the access completes.
   always_ff @(posedge clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~(req & avs_waitrequest);
      end
   end

   always_comb begin
      case (avs_address)
         OFS_CTRL:     rd_mux = ctrl_r;
         OFS_VET:      rd_mux = {16'h0000, vet_r};
         OFS_CSUM:     rd_mux = {24'h000000, csum_start_r};
         OFS_FLEX:     rd_mux = {28'h0000000, flex_r};
         OFS_STATUS:   rd_mux = {frames_r, skipped_r, 5'h00, state_r == S_FLUSH,
                                 ext_fmt_r, has_desc_r};
         OFS_BUF_SIZE: rd_mux = {16'h0000, buf_size};
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (req && avs_waitrequest) begin
         avs_readdata <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r       <= CTRL_RESET;
         vet_r        <= VET_RESET;
         csum_start_r <= CSUM_START_RESET;
         flex_r       <= FLEX_RESET;
      end else if (bus_acc && avs_write) begin
         case (avs_address)
            OFS_CTRL: ctrl_r <= merge_be(ctrl_r, avs_writedata, avs_byteenable) & 32'h0000_03FF;
            OFS_VET:  vet_r  <= 16'(merge_be({16'h0000, vet_r}, avs_writedata, avs_byteenable));
            OFS_CSUM: if (avs_byteenable[0]) csum_start_r <= avs_writedata[7:0];
            OFS_FLEX: if (avs_byteenable[0]) flex_r <= avs_writedata[3:0];
            default:  ;
         endcase
      end
   end

   // Descriptor ownership. One with the done bit still set is skipped and counted.
   always_ff @(posedge clk) begin
      if (rst) begin
         has_desc_r  <= 1'b0;
         desc_ready  <= 1'b0;
         desc_addr_r <= 64'h0000_0000_0000_0000;
         desc_size_r <= BUF_2048;
         ext_fmt_r   <= 1'b0;
         skipped_r   <= 8'h00;
      end else begin
         has_desc_r <= has_desc_nxt;
         desc_ready <= ~has_desc_nxt;
         if (take && !desc_in.word1[ST_DD]) begin
            desc_addr_r <= desc_in.buf_addr;
            desc_size_r <= buf_size;
            ext_fmt_r   <= extended_status_enable & (descriptor_type == 2'b00);
         end
         if (take && desc_in.word1[ST_DD]) begin
            skipped_r <= skipped_r + 8'h01;
         end
      end
   end

   // Input stalls while the last bytes drain or no buffer is owned.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r  <= S_STREAM;
         rx_ready <= 1'b0;
         in_idx_r <= 16'h0000;
      end else begin
         state_r  <= state_nxt;
         rx_ready <= has_desc_nxt & (state_nxt == S_STREAM);
         if (accept) begin
            in_idx_r <= rx_in.eop ? 16'h0000 : in_idx_r + 16'h0001;
         end
      end
   end

   // Two-byte pipeline, one byte of look-ahead, so the type field is known before byte 12 leaves.
   always_ff @(posedge clk) begin
      if (rst) begin
         s0_vld_r  <= 1'b0;
         s1_vld_r  <= 1'b0;
         s0_data_r <= 8'h00;
         s1_data_r <= 8'h00;
         s0_idx_r  <= 16'h0000;
         s1_idx_r  <= 16'h0000;
         s0_eop_r  <= 1'b0;
         s1_eop_r  <= 1'b0;
      end else if (shift) begin
         s1_vld_r  <= s0_vld_r;
         s1_data_r <= s0_data_r;
         s1_idx_r  <= s0_idx_r;
         s1_eop_r  <= s0_eop_r;
         s0_vld_r  <= accept;
         s0_data_r <= rx_in.data;
         s0_idx_r  <= in_idx_r;
         s0_eop_r  <= accept & rx_in.eop;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tagged_r <= 1'b0;
         tci_r    <= 16'h0000;
         meta_r   <= '0;
      end else begin
         if (close && s1_eop_r) begin
            tagged_r <= 1'b0;
         end else if (emit && s1_idx_r == TYPE_HI_IDX) begin
            tagged_r <= tag_hit;
         end
         if (accept && in_idx_r == TCI_HI_IDX) begin
            tci_r[15:8] <= rx_in.data;
         end
         if (accept && in_idx_r == TCI_LO_IDX) begin
            tci_r[7:0] <= rx_in.data;
         end
         if (accept && rx_in.eop) begin
            meta_r <= rx_meta;
         end
      end
   end

   // Store path and per-buffer byte count.
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid  <= 1'b0;
         out_data   <= 8'h00;
         out_addr   <= 64'h0000_0000_0000_0000;
         out_last   <= 1'b0;
         desc_len_r <= 16'h0000;
      end else begin
         out_valid  <= keep;
         out_data   <= s1_data_r;
         out_addr   <= desc_addr_r + {48'h0000_0000_0000, desc_len_r};
         out_last   <= emit & s1_eop_r;
         desc_len_r <= close ? 16'h0000 : desc_len_inc;
      end
   end

   // Position counts stored bytes only, so a stripped tag shifts the start offset too.
   always_ff @(posedge clk) begin
      if (rst) begin
         out_pos_r <= 16'h0000;
      end else if (accept && in_idx_r == 16'h0000) begin
         out_pos_r <= 16'h0000;
      end else if (keep) begin
         out_pos_r <= out_pos_r + 16'h0001;
      end
   end

   rx_pkt_checksum u_csum (
      .clk       (clk),
      .rst       (rst),
      .clear     (accept && in_idx_r == 16'h0000),
      .add       (keep && out_pos_r >= {8'h00, csum_start_r}),
      .high_half (~out_pos_r[0]),
      .data_byte (s1_data_r),
      .sum       (csum)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_pend_r <= 1'b0;
         wb_eop_r  <= 1'b0;
         wb_vp_r   <= 1'b0;
         wb_ext_r  <= 1'b0;
         wb_len_r  <= 16'h0000;
         frames_r  <= 16'h0000;
      end else begin
         wb_pend_r <= close;
         if (close) begin
            wb_eop_r <= s1_eop_r;
            wb_vp_r  <= tagged_r;
            wb_ext_r <= ext_fmt_r;
            wb_len_r <= desc_len_inc;
         end
         if (close && s1_eop_r) begin
            frames_r <= frames_r + 16'h0001;
         end
      end
   end

   // Frame-wide fields go only into the last buffer of a frame.
   always_ff @(posedge clk) begin
      if (rst) begin
         wb_valid <= 1'b0;
         wb_out   <= '0;
      end else begin
         wb_valid <= wb_pend_r;
         if (wb_pend_r) begin
            wb_out <= '0;
            wb_out.hi[ST_DD]  <= 1'b1;
            wb_out.hi[ST_EOP] <= wb_eop_r;
            wb_out.hi[47:32]  <= wb_len_r;
            if (wb_eop_r) begin
               wb_out.hi[63:48] <= wb_vp_r ? tci_r : 16'h0000;
               wb_out.hi[ST_VP] <= wb_vp_r;
               wb_out.hi[31:20] <= meta_r.ext_error;
               if (wb_ext_r) begin
                  wb_out.lo[63:48]    <= csum;
                  wb_out.lo[47:32]    <= meta_r.ip_ident;
                  wb_out.hi[ST_IP_IDENT_VALID] <= meta_r.ip_ident_valid;
                  wb_out.hi[ST_ACK]   <= meta_r.tcp_ack
                                         & (~meta_r.tcp_payload | ~ack_data_disable);
                  wb_out.lo[3:0]      <= rss_code(meta_r.rss_type);
                  wb_out.lo[12:8]     <= (mrq_enable == 2'b00) ? 5'h00 : meta_r.queue;
               end
            end
         end
      end
   end

endmodule

// ### design/rx_pkt_checksum.sv
module rx_pkt_checksum (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Byte feed
   input  wire logic        clear,
   input  wire logic        add,
   input  wire logic        high_half,
   input  wire logic [7:0]  data_byte,
   // Running sum
   output logic      [15:0] sum
);

   logic [16:0] raw;
   logic [15:0] folded;

   // Ones' complement addition: the carry out wraps back into bit 0.
   always_comb begin
      raw    = {1'b0, sum} + (high_half ? {1'b0, data_byte, 8'h00} : {9'h000, data_byte});
      folded = raw[15:0] + {15'h0000, raw[16]};
   end

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         sum <= 16'h0000;
      end else if (add) begin
         sum <= folded;
      end
   end

endmodule

// ### design/rx_wb_pkg.sv
package rx_wb_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [7:0]  OFS_CTRL          = 8'h00;
   localparam logic [7:0]  OFS_VET           = 8'h04;
   localparam logic [7:0]  OFS_CSUM          = 8'h08;
   localparam logic [7:0]  OFS_FLEX          = 8'h0C;
   localparam logic [7:0]  OFS_STATUS        = 8'h10;
   localparam logic [7:0]  OFS_BUF_SIZE      = 8'h14;

   // Values after reset.
   localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
   localparam logic [15:0] VET_RESET         = 16'h8100;
   localparam logic [7:0]  CSUM_START_RESET  = 8'h00;
   localparam logic [3:0]  FLEX_RESET        = 4'h0;

   // Control register field positions.
   localparam int unsigned VLAN_MODE_ENABLE          = 0;
   localparam int unsigned CTRL_EXSTEN       = 1;
   localparam int unsigned CTRL_DTYP_LO      = 2;
   localparam int unsigned CTRL_BSIZE_LO     = 4;
   localparam int unsigned CTRL_BSEX         = 6;
   localparam int unsigned CTRL_ACKD_DIS     = 7;
   localparam int unsigned CTRL_MRQE_LO      = 8;

   // Frame byte positions of the type field and the tag control field.
   localparam logic [15:0] TYPE_HI_IDX       = 16'h000C;
   localparam logic [15:0] TYPE_LO_IDX       = 16'h000D;
   localparam logic [15:0] TCI_HI_IDX        = 16'h000E;
   localparam logic [15:0] TCI_LO_IDX        = 16'h000F;

   // Write-back status bit positions.
   localparam int unsigned ST_DD             = 0;
   localparam int unsigned ST_EOP            = 1;
   localparam int unsigned ST_VP             = 3;
   localparam int unsigned ST_IP_IDENT_VALID          = 9;
   localparam int unsigned ST_ACK            = 15;

   // Receive buffer sizes in bytes.
   localparam logic [15:0] BUF_256           = 16'h0100;
   localparam logic [15:0] BUF_512           = 16'h0200;
   localparam logic [15:0] BUF_1024          = 16'h0400;
   localparam logic [15:0] BUF_2048          = 16'h0800;
   localparam logic [15:0] BUF_4096          = 16'h1000;
   localparam logic [15:0] BUF_8192          = 16'h2000;
   localparam logic [15:0] BUF_16384         = 16'h4000;

   typedef enum logic [3:0] {
      RSS_NONE   = 4'h0,
      RSS_V4_TCP = 4'h1,
      RSS_V4     = 4'h2,
      RSS_V6_TCP = 4'h3,
      RSS_V6     = 4'h5
   } rss_type_t;

   typedef struct packed {
      logic [63:0] buf_addr;
      logic [63:0] word1;
   } rx_desc_t;

   typedef struct packed {
      logic [7:0] data;
      logic       eop;
   } rx_byte_t;

   typedef struct packed {
      logic [15:0] ip_ident;
      logic        ip_ident_valid;
      logic [3:0]  rss_type;
      logic [4:0]  queue;
      logic [11:0] ext_error;
      logic        tcp_ack;
      logic        tcp_payload;
   } frame_meta_t;

   typedef struct packed {
      logic [63:0] hi;
      logic [63:0] lo;
   } wb_desc_t;

endpackage

// ### testbench/host_ring_model.sv
module host_ring_model (
   // Clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // The bench opens the ring for one descriptor per frame.
   input wire logic             fetch_en,
   // Descriptor ring
   input wire logic             desc_ready,
   output logic                 desc_valid,
   output rx_wb_pkg::rx_desc_t  desc_in
);
   timeunit 1ns;
   timeprecision 1ps;
   import rx_wb_pkg::*;
   logic [63:0] base_r;
   // Buffers sit 4 KB apart so a stray address shows which descriptor was used.
   always_ff @(posedge clk) begin
      if (rst) begin
         base_r <= 64'h0000_0001_0000_0000;
      end else if (desc_valid && desc_ready) begin
         base_r <= base_r + 64'h1000;
      end
   end
   // The format is latched at fetch, so a descriptor is offered only after setup is written.
   assign desc_valid = fetch_en && !rst;
   assign desc_in = '{base_r, 64'h0};
endmodule

// ### testbench/rx_wb_checker.sv
module rx_wb_checker (
   // Clock and reset
   input wire logic                clk,
   input wire logic                rst,
   // Observed outputs
   input wire logic                avs_waitrequest,
   input wire logic                desc_ready,
   input wire logic                rx_ready,
   input wire logic                out_last,
   input wire logic                wb_valid,
   input wire rx_wb_pkg::wb_desc_t wb_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import rx_wb_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low twice");
   property p_wb_pulse; wb_valid |=> !wb_valid; endproperty
   a_wb_pulse: assert property (p_wb_pulse) else $error("write-back not a pulse");
   property p_owned; !(desc_ready && rx_ready); endproperty
   a_owned: assert property (p_owned) else $error("ready without buffer");
   property p_done; wb_valid |-> wb_out.hi[ST_DD]; endproperty
   a_done: assert property (p_done) else $error("done bit clear");
   property p_eop; wb_valid && wb_out.hi[ST_EOP] |-> $past(out_last); endproperty
   a_eop: assert property (p_eop) else $error("end flag off last");
   property p_tag_zero; wb_valid && !wb_out.hi[ST_VP] |-> wb_out.hi[63:48] == 16'h0000;
   endproperty
   a_tag_zero: assert property (p_tag_zero) else $error("tag not zero");
   property p_st_rsv; wb_valid |-> wb_out.hi[19:16] == 4'h0 && wb_out.hi[14:11] == 4'h0;
   endproperty
   a_st_rsv: assert property (p_st_rsv) else $error("status reserved set");
   property p_mq_rsv; wb_valid |-> wb_out.lo[7:4] == 4'h0 && wb_out.lo[31:13] == 19'h0;
   endproperty
   a_mq_rsv: assert property (p_mq_rsv) else $error("queue reserved set");
   property p_rss; wb_valid |-> wb_out.lo[3:0] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
   endproperty
   a_rss: assert property (p_rss) else $error("reserved hash code");
endmodule

bind rx_descriptor_writeback rx_wb_checker rx_wb_checker_i (.clk(clk), .rst(rst),
   .avs_waitrequest(avs_waitrequest), .desc_ready(desc_ready), .rx_ready(rx_ready),
   .out_last(out_last), .wb_valid(wb_valid), .wb_out(wb_out));

// ### testbench/test_rx_descriptor_writeback.sv
module test_rx_descriptor_writeback;
   timeunit 1ns;
   timeprecision 1ps;
   import rx_wb_pkg::*;
   logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, rx_valid = 0, got;
   logic        fetch_en = 0;
   logic        avs_waitrequest, desc_valid, desc_ready, rx_ready, out_valid, out_last;
   logic        wb_valid;
   logic [7:0]  avs_address = 8'h00, out_data, f[$], s[$];
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [63:0] out_addr, last_a;
   rx_byte_t    rx_in = '0;
   frame_meta_t rx_meta = '0;
   rx_desc_t    desc_in;
   wb_desc_t    wb_out, wb_q;
   int          errors = 0, n_tests = 0, n_out;
   always #5 clk = ~clk;
   host_ring_model host_ring_model_i (.clk(clk), .rst(rst), .fetch_en(fetch_en),
      .desc_ready(desc_ready),
      .desc_valid(desc_valid), .desc_in(desc_in));
   rx_descriptor_writeback rx_descriptor_writeback_i (.clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .desc_valid(desc_valid), .desc_in(desc_in),
      .desc_ready(desc_ready), .rx_valid(rx_valid), .rx_in(rx_in), .rx_meta(rx_meta),
      .rx_ready(rx_ready), .out_valid(out_valid), .out_data(out_data), .out_addr(out_addr),
      .out_last(out_last), .wb_valid(wb_valid), .wb_out(wb_out));
   always @(posedge clk) begin
      if (out_valid) begin
         n_out <= n_out + 1;
         last_a <= out_addr;
      end
      if (wb_valid) begin
         wb_q <= wb_out;
         got <= 1'b1;
      end
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      // Waitrequest and read data are taken as they stood at the sampling edge.
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   function automatic logic [15:0] csum(input int st);
      logic [31:0] a;
      a = 0;
      for (int i = st; i < s.size(); i++) a += (i % 2 == 0) ? {s[i], 8'h00} : s[i];
      while (a[31:16] != 0) a = a[15:0] + a[31:16];
      return a[15:0];
   endfunction
   task automatic frame(input logic strip);
      int   n;
      f.delete();
      s.delete();
      for (int i = 0; i < 24; i++) f.push_back(8'h20 + i[7:0]);
      f[12] = 8'h81;
      f[13] = 8'h00;
      f[14] = 8'hE5;
      f[15] = 8'h67;
      foreach (f[i]) if (!strip || i < 12 || i > 15) s.push_back(f[i]);
      n_out = 0;
      got = 1'b0;
      fetch_en <= 1'b1;
      foreach (f[i]) begin
         rx_valid <= 1'b1;
         rx_in <= '{f[i], i == 23};
         do begin
            @(posedge clk);
         end while (rx_ready !== 1'b1);
         fetch_en <= 1'b0;
      end
      rx_valid <= 1'b0;
      for (n = 0; got !== 1'b1 && n < 40; n++) @(negedge clk);
      chk(got, 1);
   endtask
   task automatic print_verdict;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      print_verdict;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(0, OFS_VET, 0);
      chk(q, 32'h8100);
      bus(0, 8'h3C, 0);
      chk(q, 0);
      bus(0, OFS_BUF_SIZE, 0);
      chk(q, BUF_2048);
      bus(1, OFS_CTRL, 32'h60);
      bus(0, OFS_BUF_SIZE, 0);
      chk(q, BUF_8192);
      bus(1, OFS_FLEX, 32'h4);
      bus(0, OFS_BUF_SIZE, 0);
      chk(q, BUF_4096);
      $display("register test done");
      bus(1, OFS_FLEX, 0);
      bus(1, OFS_CTRL, 32'h103);
      rx_meta <= '{16'hBEEF, 1'b1, RSS_V4_TCP, 5'd5, 12'hA50, 1'b1, 1'b0};
      frame(1);
      chk(wb_q.hi[63:20], {16'hE567, 16'd20, 12'hA50});
      chk(n_out, 20);
      chk(last_a, 64'h1_0000_0013);
      chk(wb_q.lo[63:32], {csum(0), 16'hBEEF});
      chk(wb_q.lo[12:0], 13'h0501);
      chk({wb_q.hi[15], wb_q.hi[1:0]}, 3'b111);
      $display("tagged frame test done");
      bus(1, OFS_CTRL, 32'h2);
      bus(1, OFS_CSUM, 32'h2);
      rx_meta.rss_type <= 4'h6;
      rx_meta.tcp_ack <= 1'b0;
      frame(0);
      chk(wb_q.hi[63:32], {16'h0000, 16'd24});
      chk(wb_q.lo[63:48], csum(2));
      chk(wb_q.lo[12:0], 13'h0000);
      chk(wb_q.hi[15], 0);
      chk(last_a, 64'h1_0000_1017);
      $display("untagged frame test done");
      bus(1, OFS_CTRL, 32'h0);
      frame(0);
      chk(wb_q.lo, 64'h0);
      $display("legacy format test done");
      print_verdict;
   end
endmodule
